//--- rtl/rstio_clkdiv.v
// Purpose: Divide the input clock by two for the internal rate.
// Assumes: Runs from the core clock with the shared enable.
// Notes:   Tick marks one edge of each internal period.
`timescale 1ns/1ps
`default_nettype none
module rstio_clkdiv (
	input  wire clk_in,
	input  wire rst_in,
	input  wire en_in,
	output wire tick_out,
	output wire clk_out
);
	reg phase_q;  // Internal clock phase
	// Toggle once per input edge; one full period per two edges
	always @(posedge clk_in) begin
		if (rst_in) begin
			phase_q <= 1'b0;
		end else if (en_in) begin
			phase_q <= ~phase_q;
		end
	end
	assign tick_out = phase_q;
	assign clk_out  = phase_q;
endmodule
`default_nettype wire

//--- rtl/rstio_regs.vh
// Purpose: Constants for the restart interrupt and serial I/O block.
// Assumes: Included by its bare name; definitions only.
// Notes:   Offsets are byte addresses on the AXI4-Lite register port.
//
// Behaviour
// - Fixed priority nmi, edge, hi, lo, general
// - Three restart masks; nonmaskable input unmasked
// - Maskable restart needs enable set, mask clear
// - Nonmaskable restarts regardless of enable, masks
// - Hi and lo levels sampled like general
// - Rising edge latches request until serviced
// - Edge latch cleared by set-mask or reset
// - Edge latch sets even while masked
// - Priority ignores routine currently running
// - Nonmaskable rearms only after low then high
// - Any service clears global enable until enable
// - First mask read after nmi shows saved
// - Mask read after maskable shows disabled
// - Hold and interrupt inputs synchronised first
// - Internal clock is input divided by two
// - Fixed restart vectors per input
// - Reset clears global interrupt enable
// - Serial in lands in status bit seven
`ifndef RSTIO_REGS_VH
`define RSTIO_REGS_VH

// Register byte offsets
`define RSTIO_OFF_CTRL     8'h00
`define RSTIO_OFF_STAT     8'h04
`define RSTIO_OFF_CMD      8'h08
`define RSTIO_OFF_LAST     8'h0C

// Set-mask word fields
`define RSTIO_CTRL_MASK_LO 0
`define RSTIO_CTRL_MASK_HI 2
`define RSTIO_CTRL_MSE     3
`define RSTIO_CTRL_ECLR    4
`define RSTIO_CTRL_SOE     6
`define RSTIO_CTRL_SOD     7

// Read-mask word fields
`define RSTIO_STAT_IE      3
`define RSTIO_STAT_PND_LO  4
`define RSTIO_STAT_PND_HI  6
`define RSTIO_STAT_SID     7

// Command word fields
`define RSTIO_CMD_EI       0
`define RSTIO_CMD_DI       1

// Reset values
`define RSTIO_MASK_RST     3'h7

// Restart vectors
`define RSTIO_VEC_NMI      8'h24
`define RSTIO_VEC_EDGE     8'h3C
`define RSTIO_VEC_HI       8'h34
`define RSTIO_VEC_LO       8'h2C
`define RSTIO_VEC_GEN      8'h00

// Bus responses
`define RSTIO_RESP_OKAY    2'h0
`define RSTIO_RESP_SLVERR  2'h2

// Clocking: core rate and least input rate, in MHz
`define RSTIO_CLK_MHZ      100
`define RSTIO_XIN_MIN_MHZ  1
`define RSTIO_DIV          2

`endif

//--- rtl/rstio_sync.v
// Purpose: Two-stage synchroniser, one lane per bit.
// Assumes: Inputs are asynchronous pins.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module rstio_sync #(
	parameter WIDTH = 7
) (
	input  wire             clk_in,
	input  wire             rst_in,
	input  wire             en_in,
	input  wire [WIDTH-1:0] d_in,
	output wire [WIDTH-1:0] q_out
);
	genvar g;
	// One pair of flops per lane
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_lane
			reg meta_q;  // Possibly metastable stage
			reg stab_q;  // Stable stage
			always @(posedge clk_in) begin
				if (rst_in) begin
					meta_q <= 1'b0;
					stab_q <= 1'b0;
				end else if (en_in) begin
					meta_q <= d_in[g];
					stab_q <= meta_q;
				end
			end
			assign q_out[g] = stab_q;
		end
	endgenerate
endmodule
`default_nettype wire

//--- rtl/rstio_top.v
// Purpose: Interrupt recognition, priority and serial bit port.
// Assumes: Core boundary strobe comes from logic on core_clk_in.
// Notes:   Mask read has a side effect on the saved enable.
`timescale 1ns/1ps
`default_nettype none
`include "rstio_regs.vh"
module rstio_top (
	input  wire        core_clk_in,
	input  wire        sys_rst_in,
	input  wire        clk_en_in,
	// AXI4-Lite write address
	input  wire [7:0]  s_axi_awaddr_in,
	input  wire        s_axi_awvalid_in,
	output wire        s_axi_awready_out,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata_in,
	input  wire [3:0]  s_axi_wstrb_in,
	input  wire        s_axi_wvalid_in,
	output wire        s_axi_wready_out,
	// AXI4-Lite write response
	output wire [1:0]  s_axi_bresp_out,
	output wire        s_axi_bvalid_out,
	input  wire        s_axi_bready_in,
	// AXI4-Lite read address
	input  wire [7:0]  s_axi_araddr_in,
	input  wire        s_axi_arvalid_in,
	output wire        s_axi_arready_out,
	// AXI4-Lite read data
	output wire [31:0] s_axi_rdata_out,
	output wire [1:0]  s_axi_rresp_out,
	output wire        s_axi_rvalid_out,
	input  wire        s_axi_rready_in,
	// Interrupt pins
	input  wire        nonmaskable_irq_in,
	input  wire        edge_restart_irq_in,
	input  wire        level_restart_irq_hi_in,
	input  wire        level_restart_irq_lo_in,
	input  wire        general_irq_in,
	input  wire        hold_req_in,
	input  wire        serial_in_line_in,
	// Instruction core side
	input  wire        core_boundary_in,
	output wire        restart_take_out,
	output wire [7:0]  restart_vec_out,
	output wire        restart_general_out,
	output wire        irq_acknowledge_n_out,
	output wire        irq_enable_out,
	output wire        hold_sync_out,
	output wire        serial_out_line_out,
	output wire        int_clk_out
);

	// Synchronised pin levels
	wire [6:0] sy;
	wire       sy_trap = sy[0];
	wire       sy_edge = sy[1];
	wire       sy_hi   = sy[2];
	wire       sy_lo   = sy[3];
	wire       sy_gen  = sy[4];
	wire       sy_sid  = sy[5];
	wire       tick;     // One core edge per internal period

	// Every asynchronous pin passes two flops before any logic reads it
	rstio_sync #(
		.WIDTH (7)
	) u_sync (
		.clk_in (core_clk_in),
		.rst_in (sys_rst_in),
		.en_in  (clk_en_in),
		.d_in   ({hold_req_in, serial_in_line_in, general_irq_in,
			level_restart_irq_lo_in, level_restart_irq_hi_in,
			edge_restart_irq_in, nonmaskable_irq_in}),
		.q_out  (sy)
	);

	// Internal clock at half the core rate
	rstio_clkdiv u_div (
		.clk_in   (core_clk_in),
		.rst_in   (sys_rst_in),
		.en_in    (clk_en_in),
		.tick_out (tick),
		.clk_out  (int_clk_out)
	);

	// Interrupt state
	reg [2:0]  mask_q;       // [0] lo, [1] hi, [2] edge
	reg        ie_q;         // Global enable
	reg        edge_flag_q;  // Latched edge request
	reg        edge_prev_q;  // Last edge level seen
	reg        trap_prev_q;  // Last nmi level seen
	reg        trap_armed_q; // Nmi rising edge awaiting service
	reg        saved_ie_q;   // Enable before the last nmi
	reg        saved_vld_q;  // Saved enable not yet read
	reg        hi_s_q;       // Hi level sampled at internal edge
	reg        lo_s_q;       // Lo level sampled at internal edge
	reg        gen_s_q;      // General level sampled at internal edge
	reg        sod_q;        // Serial out level
	reg        hold_q;       // Hold level for the core
	reg [7:0]  last_vec_q;   // Vector of the last service
	reg        take_q;       // Service pulse to the core
	reg [7:0]  vec_q;        // Vector offered with the pulse
	reg        gen_q;        // Service is for the general input
	reg        ack_n_q;      // Acknowledge, low for one cycle

	// Bus state
	reg        awready_q;
	reg        aw_full_q;
	reg [7:0]  aw_addr_q;
	reg        wready_q;
	reg        w_full_q;
	reg [31:0] w_data_q;
	reg [3:0]  w_strb_q;
	reg        bvalid_q;
	reg [1:0]  bresp_q;
	reg        arready_q;
	reg        rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0]  rresp_q;

	// Edge detectors on synchronised levels
	wire edge_rise = sy_edge & ~edge_prev_q;
	wire trap_rise = sy_trap & ~trap_prev_q;

	// Requests qualified by masks and enable, general by enable only; nmi by neither
	wire req_trap = trap_armed_q & sy_trap;
	wire req_edge = edge_flag_q & ie_q & ~mask_q[2];
	wire req_hi   = hi_s_q & ie_q & ~mask_q[1];
	wire req_lo   = lo_s_q & ie_q & ~mask_q[0];
	wire req_gen  = gen_s_q & ie_q;
	wire req_any  = req_trap | req_edge | req_hi | req_lo | req_gen;

	// Service only at an internal edge on an instruction boundary;
	// the core needs one cycle to see the pulse before the next.
	wire service  = tick & core_boundary_in & req_any & ~take_q;

	// Winner by fixed order; running routine plays no part
	reg [7:0] win_vec;
	reg [2:0] win_id;   // 0 nmi, 1 edge, 2 hi, 3 lo, 4 general
	always @* begin
		win_vec = `RSTIO_VEC_GEN;
		win_id  = 3'h4;
		if (req_trap) begin
			win_vec = `RSTIO_VEC_NMI;
			win_id  = 3'h0;
		end else if (req_edge) begin
			win_vec = `RSTIO_VEC_EDGE;
			win_id  = 3'h1;
		end else if (req_hi) begin
			win_vec = `RSTIO_VEC_HI;
			win_id  = 3'h2;
		end else if (req_lo) begin
			win_vec = `RSTIO_VEC_LO;
			win_id  = 3'h3;
		end
	end

	// Bus decode
	wire aw_take = s_axi_awvalid_in & awready_q;
	wire w_take  = s_axi_wvalid_in & wready_q;
	wire ar_take = s_axi_arvalid_in & arready_q;
	wire do_wr   = aw_full_q & w_full_q & ~bvalid_q;
	wire wr_lane = do_wr & w_strb_q[0];  // Fields all sit in byte 0
	wire wr_ctrl = wr_lane & (aw_addr_q == `RSTIO_OFF_CTRL);
	wire wr_cmd  = wr_lane & (aw_addr_q == `RSTIO_OFF_CMD);
	wire wr_ok   = (aw_addr_q == `RSTIO_OFF_CTRL) |
		(aw_addr_q == `RSTIO_OFF_CMD);
	wire rd_stat = ar_take & (s_axi_araddr_in == `RSTIO_OFF_STAT);

	// Read-mask word; saved enable shows once after nmi
	wire [7:0] stat_word = {sy_sid,
		edge_flag_q, hi_s_q, lo_s_q,
		(saved_vld_q ? saved_ie_q : ie_q),
		mask_q};

	// Read data mux
	reg [31:0] rd_mux;
	reg        rd_hit;
	always @* begin
		rd_mux = 32'h0;
		rd_hit = 1'b1;
		case (s_axi_araddr_in)
			`RSTIO_OFF_CTRL: begin
				rd_mux = {24'h0, sod_q, 4'h0, mask_q};
			end
			`RSTIO_OFF_STAT: begin
				rd_mux = {24'h0, stat_word};
			end
			`RSTIO_OFF_CMD: begin
				rd_mux = {31'h0, ie_q};
			end
			`RSTIO_OFF_LAST: begin
				rd_mux = {24'h0, last_vec_q};
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// Interrupt state machine; clock enable freezes everything
	always @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			mask_q       <= `RSTIO_MASK_RST;
			ie_q         <= 1'b0;
			edge_flag_q  <= 1'b0;
			edge_prev_q  <= 1'b0;
			trap_prev_q  <= 1'b0;
			trap_armed_q <= 1'b0;
			saved_ie_q   <= 1'b0;
			saved_vld_q  <= 1'b0;
			hi_s_q       <= 1'b0;
			lo_s_q       <= 1'b0;
			gen_s_q      <= 1'b0;
			sod_q        <= 1'b0;
			hold_q       <= 1'b0;
			last_vec_q   <= 8'h00;
			take_q       <= 1'b0;
			vec_q        <= 8'h00;
			gen_q        <= 1'b0;
			ack_n_q      <= 1'b1;
		end else if (clk_en_in) begin
			edge_prev_q <= sy_edge;
			trap_prev_q <= sy_trap;
			hold_q      <= sy[6];
			// Levels are sampled once per internal period
			if (tick) begin
				hi_s_q  <= sy_hi;
				lo_s_q  <= sy_lo;
				gen_s_q <= sy_gen;
			end
			// Edge latch: a new edge beats any clear in the same cycle
			if (edge_rise) begin
				edge_flag_q <= 1'b1;
			end else if (service & (win_id == 3'h1)) begin
				edge_flag_q <= 1'b0;
			end else if (wr_ctrl & w_data_q[`RSTIO_CTRL_ECLR]) begin
				edge_flag_q <= 1'b0;
			end
			// Nmi arms on a rise only; a held level cannot retrigger
			if (trap_rise) begin
				trap_armed_q <= 1'b1;
			end else if (service & (win_id == 3'h0)) begin
				trap_armed_q <= 1'b0;
			end
			// Set-mask write: masks and serial out each gated
			if (wr_ctrl) begin
				if (w_data_q[`RSTIO_CTRL_MSE]) begin
					mask_q <= w_data_q[`RSTIO_CTRL_MASK_HI:`RSTIO_CTRL_MASK_LO];
				end
				if (w_data_q[`RSTIO_CTRL_SOE]) begin
					sod_q <= w_data_q[`RSTIO_CTRL_SOD];
				end
			end
			// Global enable: service beats a same-cycle enable
			if (service) begin
				ie_q <= 1'b0;
			end else if (wr_cmd & w_data_q[`RSTIO_CMD_EI]) begin
				ie_q <= 1'b1;
			end else if (wr_cmd & w_data_q[`RSTIO_CMD_DI]) begin
				ie_q <= 1'b0;
			end
			// Saved enable: an nmi service beats a same-cycle read
			if (service & (win_id == 3'h0)) begin
				saved_ie_q  <= ie_q;
				saved_vld_q <= 1'b1;
			end else if (rd_stat) begin
				saved_vld_q <= 1'b0;
			end
			// Offer the service to the core
			take_q  <= service;
			ack_n_q <= ~(service & (win_id == 3'h4));
			if (service) begin
				vec_q      <= win_vec;
				gen_q      <= (win_id == 3'h4);
				last_vec_q <= win_vec;
			end
		end
	end

	// AXI4-Lite write channel: address and data in either order
	always @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			awready_q <= 1'b1;
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			wready_q  <= 1'b1;
			w_full_q  <= 1'b0;
			w_data_q  <= 32'h0;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `RSTIO_RESP_OKAY;
		end else if (clk_en_in) begin
			if (aw_take) begin
				awready_q <= 1'b0;
				aw_full_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr_in[7:2], 2'h0};
			end
			if (w_take) begin
				wready_q <= 1'b0;
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata_in;
				w_strb_q <= s_axi_wstrb_in;
			end
			// Both halves held: perform and answer
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_ok ? `RSTIO_RESP_OKAY : `RSTIO_RESP_SLVERR;
			end else if (bvalid_q & s_axi_bready_in) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel: one read under way at a time
	always @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= `RSTIO_RESP_OKAY;
		end else if (clk_en_in) begin
			if (ar_take) begin
				arready_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rdata_q   <= rd_mux;
				rresp_q   <= rd_hit ? `RSTIO_RESP_OKAY : `RSTIO_RESP_SLVERR;
			end else if (rvalid_q & s_axi_rready_in) begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// Outputs straight from flops
	assign s_axi_awready_out     = awready_q;
	assign s_axi_wready_out      = wready_q;
	assign s_axi_bvalid_out      = bvalid_q;
	assign s_axi_bresp_out       = bresp_q;
	assign s_axi_arready_out     = arready_q;
	assign s_axi_rvalid_out      = rvalid_q;
	assign s_axi_rdata_out       = rdata_q;
	assign s_axi_rresp_out       = rresp_q;
	assign restart_take_out      = take_q;
	assign restart_vec_out       = vec_q;
	assign restart_general_out   = gen_q;
	assign irq_acknowledge_n_out = ack_n_q;
	assign irq_enable_out        = ie_q;
	assign hold_sync_out         = hold_q;
	assign serial_out_line_out   = sod_q;

endmodule
`default_nettype wire

//--- tb/rstio_chk_sva.sv
// Purpose: Timing checks on restart service, enable and serial out.
// Assumes: Bound to rstio_top; one clock domain.
// Notes:   Watches the block outputs, with hold_req_in and clk_en_in as references.
`timescale 1ns/1ps
`default_nettype none
module rstio_chk (
	input wire logic       core_clk_in,
	input wire logic       sys_rst_in,
	input wire logic       clk_en_in,
	input wire logic       hold_req_in,
	input wire logic       restart_take_out,
	input wire logic [7:0] restart_vec_out,
	input wire logic       restart_general_out,
	input wire logic       irq_acknowledge_n_out,
	input wire logic       irq_enable_out,
	input wire logic       hold_sync_out,
	input wire logic       serial_out_line_out,
	input wire logic       s_axi_bvalid_out,
	input wire logic       int_clk_out
);
	// Shared clock and reset for every check
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	// Service is a single-cycle pulse
	property p_take_one; restart_take_out |=> !restart_take_out; endproperty
	a_take_one: assert property (p_take_one) else $error("service pulse too long");
	// Any service leaves the global enable clear
	property p_take_off; restart_take_out |-> !irq_enable_out; endproperty
	a_take_off: assert property (p_take_off) else $error("enable kept on service");
	// Fixed vectors; general service carries none of its own
	property p_vec;
		restart_take_out |-> (restart_general_out ? restart_vec_out == 8'h00
			: restart_vec_out inside {8'h24, 8'h3C, 8'h34, 8'h2C});
	endproperty
	a_vec: assert property (p_vec) else $error("bad restart vector");
	// Acknowledge strobe only with a general service
	property p_ack; (restart_take_out && restart_general_out) == !irq_acknowledge_n_out; endproperty
	a_ack: assert property (p_ack) else $error("acknowledge mismatch");
	// Maskable service needs the enable on just before
	property p_need_en;
		$rose(restart_take_out) && restart_vec_out != 8'h24 |-> $past(irq_enable_out);
	endproperty
	a_need_en: assert property (p_need_en) else $error("service while disabled");
	// Enable rises only when a bus write completes
	property p_en_rise; $rose(irq_enable_out) |-> $rose(s_axi_bvalid_out); endproperty
	a_en_rise: assert property (p_en_rise) else $error("enable rose without write");
	// Internal clock flips on every enabled edge
	property p_div; clk_en_in |=> int_clk_out != $past(int_clk_out); endproperty
	a_div: assert property (p_div) else $error("internal clock not halved");
	// Hold output follows its pin three edges late
	property p_hold;
		hold_sync_out != $past(hold_sync_out) |-> hold_sync_out == $past(hold_req_in, 3);
	endproperty
	a_hold: assert property (p_hold) else $error("hold sync wrong");
	// Serial out moves only as a write completes
	property p_sod; serial_out_line_out != $past(serial_out_line_out) |-> $rose(s_axi_bvalid_out); endproperty
	a_sod: assert property (p_sod) else $error("serial out moved alone");
endmodule
bind rstio_top rstio_chk i_rstio_chk (
	.core_clk_in, .sys_rst_in, .clk_en_in, .hold_req_in, .restart_take_out, .restart_vec_out,
	.restart_general_out, .irq_acknowledge_n_out, .irq_enable_out, .hold_sync_out,
	.serial_out_line_out, .s_axi_bvalid_out, .int_clk_out
);
`default_nettype wire

//--- tb/rstio_src_model.sv
// Purpose: Interrupt sources and serial input line outside the block.
// Assumes: Fire strobes come from the bench, one cycle each.
// Notes:   Levels drop only once their own service is seen.
`timescale 1ns/1ps
`default_nettype none
module rstio_src (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [4:0] fire_in,
	input  wire logic       sdat_in,
	input  wire logic       take_in,
	input  wire logic [7:0] vec_in,
	input  wire logic       ack_n_in,
	output logic      [4:0] irq_out,
	output logic            sin_out
);
	logic [2:0] cnt_q; // Edge pulse length left
	// Bit 0 nonmaskable, 1 edge, 2 hi, 3 lo, 4 general
	always @(posedge clk_in) begin
		if (rst_in) begin
			irq_out <= 5'h00;
			cnt_q   <= 3'h0;
		end else begin
			// Held high until its own service pulse is seen, then low
			irq_out[0] <= fire_in[0] | (irq_out[0] & !(take_in && vec_in == 8'h24));
			// Short pulse, long enough to pass the synchroniser
			cnt_q      <= fire_in[1] ? 3'h4 : cnt_q - {2'h0, cnt_q != 3'h0};
			irq_out[1] <= fire_in[1] | (cnt_q > 3'h1);
			// Levels stay up until sampled and serviced
			irq_out[2] <= fire_in[2] | (irq_out[2] & !(take_in && vec_in == 8'h34));
			irq_out[3] <= fire_in[3] | (irq_out[3] & !(take_in && vec_in == 8'h2C));
			irq_out[4] <= fire_in[4] | (irq_out[4] & ack_n_in);
		end
		sin_out <= sdat_in;
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench against a queue-based reference model.
// Assumes: Register map and vectors from rstio_regs.vh.
// Notes:   Every service is queued and checked in order.
`timescale 1ns/1ps
`default_nettype none
`include "rstio_regs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb_top;
	logic        core_clk_in      = 1'b0;
	logic        sys_rst_in       = 1'b1;
	logic        clk_en_in        = 1'b1;
	logic [7:0]  s_axi_awaddr_in  = 8'h00;
	logic        s_axi_awvalid_in = 1'b0;
	logic [31:0] s_axi_wdata_in   = 32'h0;
	logic [3:0]  s_axi_wstrb_in   = 4'hF;
	logic        s_axi_wvalid_in  = 1'b0;
	logic        s_axi_bready_in  = 1'b1;
	logic [7:0]  s_axi_araddr_in  = 8'h00;
	logic        s_axi_arvalid_in = 1'b0;
	logic        s_axi_rready_in  = 1'b1;
	logic        core_boundary_in = 1'b1;
	logic        hold_req_in      = 1'b0;
	logic [4:0]  fire_bits        = 5'h00;
	logic        sdat             = 1'b0;
	wire         nonmaskable_irq_in, edge_restart_irq_in, level_restart_irq_hi_in;
	wire         level_restart_irq_lo_in, general_irq_in, serial_in_line_in;
	logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic        s_axi_rvalid_out, restart_take_out, restart_general_out, irq_acknowledge_n_out;
	logic        irq_enable_out, hold_sync_out, serial_out_line_out, int_clk_out;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
	logic [31:0] s_axi_rdata_out;
	logic [7:0]  restart_vec_out;
	// Reference model state
	logic [2:0]  mask  = 3'h7;
	logic        ie    = 1'b0;
	logic        saved = 1'b0;
	logic        sv    = 1'b0;
	logic        serial_out_line   = 1'b0;
	logic [4:0]  pend  = 5'h00;
	logic [8:0]  tq[$];
	int          fail_count   = 0;
	int          total_checks = 0;
	int          seed         = 32'h11161389;

	rstio_top i_rstio_top (
		.core_clk_in, .sys_rst_in, .clk_en_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
		.s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
		.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
		.s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .nonmaskable_irq_in,
		.edge_restart_irq_in, .level_restart_irq_hi_in, .level_restart_irq_lo_in, .general_irq_in,
		.hold_req_in, .serial_in_line_in, .core_boundary_in, .restart_take_out, .restart_vec_out,
		.restart_general_out, .irq_acknowledge_n_out, .irq_enable_out, .hold_sync_out,
		.serial_out_line_out, .int_clk_out
	);
	rstio_src i_rstio_src (
		.clk_in(core_clk_in), .rst_in(sys_rst_in), .fire_in(fire_bits), .sdat_in(sdat),
		.take_in(restart_take_out), .vec_in(restart_vec_out), .ack_n_in(irq_acknowledge_n_out),
		.irq_out({general_irq_in, level_restart_irq_lo_in, level_restart_irq_hi_in,
			edge_restart_irq_in, nonmaskable_irq_in}), .sin_out(serial_in_line_in)
	);

	// 100 MHz input, the block halves it internally
	always #5 core_clk_in = ~core_clk_in;
	// Queue each service as {general, vector}
	always @(posedge core_clk_in) if (restart_take_out === 1'b1) tq.push_back({restart_general_out, restart_vec_out});

	task automatic finish_test;
		if (fail_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Write: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		begin
			@(posedge core_clk_in);
			s_axi_awaddr_in  <= a;
			s_axi_wdata_in   <= d;
			s_axi_awvalid_in <= 1'b1;
			s_axi_wvalid_in  <= 1'b1;
			do begin
				@(posedge core_clk_in);
				if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
				if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
			end while (!s_axi_bvalid_out);
			`CHK(s_axi_bresp_out, er)
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		begin
			@(posedge core_clk_in);
			s_axi_araddr_in  <= a;
			s_axi_arvalid_in <= 1'b1;
			do begin
				@(posedge core_clk_in);
				if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
			end while (!s_axi_rvalid_out);
			`CHK(s_axi_rdata_out, ed)
			`CHK(s_axi_rresp_out, er)
		end
	endtask
	// Status read; the saved enable shows once only
	task automatic rd_stat;
		begin
			rd(`RSTIO_OFF_STAT, {24'h0, sdat, pend[1], pend[2], pend[3], sv ? saved : ie, mask}, 2'h0);
			sv = 1'b0;
		end
	endtask
	task automatic wctl(input logic [7:0] d);
		begin
			wr(`RSTIO_OFF_CTRL, {24'h0, d}, 2'h0);
			if (d[3]) mask = d[2:0];
			if (d[4]) pend[1] = 1'b0;
			if (d[6]) serial_out_line = d[7];
			`CHK(serial_out_line_out, serial_out_line)
		end
	endtask
	task automatic wcmd(input logic [1:0] d);
		begin
			wr(`RSTIO_OFF_CMD, {30'h0, d}, 2'h0);
			if (d[0]) ie = 1'b1;
			else if (d[1]) ie = 1'b0;
		end
	endtask
	// Pulse the sources, then let the synchronisers settle
	task automatic fire(input logic [4:0] b);
		@(posedge core_clk_in);
		fire_bits <= b;
		@(posedge core_clk_in);
		fire_bits <= 5'h00;
		pend = pend | b;
		repeat (8) @(posedge core_clk_in);
	endtask
	// Next service by fixed priority, or -1 if none may run
	function automatic int exp_vec();
		if (pend[0]) return `RSTIO_VEC_NMI;
		if (!ie) return -1;
		if (pend[1] && !mask[2]) return `RSTIO_VEC_EDGE;
		if (pend[2] && !mask[1]) return `RSTIO_VEC_HI;
		if (pend[3] && !mask[0]) return `RSTIO_VEC_LO;
		if (pend[4]) return 32'h100;
		return -1;
	endfunction
	// Match every queued service against the model, then expect silence
	task automatic run;
		int         e;
		int         n;
		logic [8:0] got;
		logic       ck;
		begin
			e = exp_vec();
			while (e >= 0) begin
				n = 0;
				while (tq.size() == 0 && n++ < 100) @(posedge core_clk_in);
				// Pop once only; an empty queue gives a value no service can have
				got = (tq.size() > 0) ? tq.pop_front() : 9'h1FF;
				`CHK(got, e[8:0])
				case (e)
					32'h24: begin
						saved   = ie;
						sv      = 1'b1;
						pend[0] = 1'b0;
					end
					32'h3C: pend[1] = 1'b0;
					32'h34: pend[2] = 1'b0;
					32'h2C: pend[3] = 1'b0;
					default: pend[4] = 1'b0;
				endcase
				ie = 1'b0;
				e = exp_vec();
			end
			repeat (20) @(posedge core_clk_in);
			`CHK(tq.size(), 0)
			`CHK(irq_enable_out, ie)
			// Internal clock must differ at two neighbouring edges
			ck = int_clk_out;
			@(posedge core_clk_in);
			`CHK(int_clk_out, ~ck)
		end
	endtask

	// Watchdog: the run needs a few thousand cycles at most
	initial begin
		#200us;
		fail_count++;
		finish_test;
	end
	initial begin
		repeat (20) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		rd(`RSTIO_OFF_CTRL, 32'h7, 2'h0);
		rd_stat;
		rd(8'h10, 32'h0, 2'h2);
		wr(`RSTIO_OFF_STAT, 32'h0, 2'h2);
		wcmd(2'h1);
		fire(5'h0F);
		run;
		rd_stat;
		rd_stat;
		wctl(8'h08);
		repeat (3) begin
			wcmd(2'h1);
			run;
			rd_stat;
		end
		fire(5'h10);
		wcmd(2'h1);
		run;
		wctl(8'h0C);
		fire(5'h02);
		rd_stat;
		wctl(8'h1C);
		rd_stat;
		// Mid-run reset with a masked edge latched and enable set
		fire(5'h02);
		wcmd(2'h1);
		sys_rst_in <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		mask = 3'h7;
		ie   = 1'b0;
		pend = 5'h00;
		sv   = 1'b0;
		serial_out_line  = 1'b0;
		rd_stat;
		`CHK(irq_enable_out, ie)
		// Random masks, sources, enable and serial lines
		repeat (16) begin
			sdat        <= 1'($random(seed));
			hold_req_in <= 1'($random(seed));
			wcmd(2'h2);
			wctl(8'($random(seed)));
			fire(5'($random(seed)));
			run;
			wcmd(2'($random(seed)));
			run;
			rd_stat;
			rd(`RSTIO_OFF_CTRL, {24'h0, serial_out_line, 4'h0, mask}, 2'h0);
			`CHK(hold_sync_out, hold_req_in)
		end
		finish_test;
	end
endmodule
`default_nettype wire
